/* File: logic/fwp_core.sv */
// serial command decoder, write enable latch, protection bits and software reset
`timescale 1ns/10ps
module fwp_core #(
    parameter int ADDR_W = fwp_pkg::ADDR_W,
    parameter int RESET_CYCLES = fwp_pkg::RESET_CYCLES
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // serial pins
    input wire logic spi_sck,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    input wire logic wp_n,
    // status write requests
    input wire logic sr_write_req,
    input fwp_pkg::fwp_protect_s sr_write_bits,
    output logic sr_write_done,
    output logic sr_write_refused,
    // program and erase requests
    input wire logic array_req,
    input fwp_pkg::fwp_region_s array_region,
    output logic array_grant,
    output logic array_refused,
    // volatile state load
    input wire logic volatile_load,
    input fwp_pkg::fwp_volatile_s volatile_value,
    // status
    output logic write_enable_latch,
    output fwp_pkg::fwp_protect_s protect_bits,
    output fwp_pkg::fwp_volatile_s volatile_state,
    output logic reset_enabled,
    output logic reset_busy,
    output logic soft_reset_pulse
);
    localparam int CNT_W = $clog2(RESET_CYCLES + 1);

    // ********************************
    // pin synchronisers
    // ********************************
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic sck_q;
    logic cs_q;
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            // idle pin levels: write-protect high, select high, serial clock low
            pin_s1 <= 4'hA;
            pin_s2 <= 4'hA;
            sck_q <= 1'b0;
            cs_q <= 1'b1;
        end
        else
        begin
            pin_s1 <= {wp_n, spi_mosi, spi_cs_n, spi_sck};
            pin_s2 <= pin_s1;
            sck_q <= pin_s2[0];
            cs_q <= pin_s2[1];
        end
    end
    logic sck_s;
    logic cs_s;
    logic mosi_s;
    logic wp_s;
    assign sck_s = pin_s2[0];
    assign cs_s = pin_s2[1];
    assign mosi_s = pin_s2[2];
    assign wp_s = pin_s2[3];
    logic sck_rise;
    logic cs_rise;
    assign sck_rise = !cs_s && sck_s && !sck_q; // RQ17
    assign cs_rise = cs_s && !cs_q;

    // ********************************
    // opcode shifter
    // ********************************
    logic [7:0] shifter;
    logic [7:0] opcode;
    logic [2:0] bit_cnt;
    logic opcode_done;
    logic [7:0] next_shifter;
    logic [7:0] next_opcode;
    logic [2:0] next_bit_cnt;
    logic next_opcode_done;
    always_comb
    begin
        next_shifter = shifter;
        next_opcode = opcode;
        next_bit_cnt = bit_cnt;
        next_opcode_done = opcode_done;
        if (cs_rise)
        begin
            next_bit_cnt = 3'h0;
            next_opcode_done = 1'b0;
        end
        else if (sck_rise)
        begin
            next_shifter = {shifter[6:0], mosi_s}; // RQ17
            next_bit_cnt = bit_cnt + 3'h1;
            // only the first byte is kept; later bits just keep the count going
            if (bit_cnt == fwp_pkg::BIT_LAST && !opcode_done)
            begin
                next_opcode = {shifter[6:0], mosi_s}; // RQ3
                next_opcode_done = 1'b1;
            end
        end
    end
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            shifter <= 8'h00;
            opcode <= 8'h00;
            bit_cnt <= 3'h0;
            opcode_done <= 1'b0;
        end
        else
        begin
            shifter <= next_shifter;
            opcode <= next_opcode;
            bit_cnt <= next_bit_cnt;
            opcode_done <= next_opcode_done;
        end
    end
    logic frame_ok;
    assign frame_ok = cs_rise && opcode_done && bit_cnt == 3'h0 && !reset_busy; // RQ4 RQ14

    // ********************************
    // reset sequence
    // ********************************
    fwp_pkg::fwp_reset_e rst_state;
    fwp_pkg::fwp_reset_e next_rst_state;
    logic [CNT_W-1:0] rst_cnt;
    logic [CNT_W-1:0] next_rst_cnt;
    logic next_soft_reset;
    always_comb
    begin
        next_rst_state = rst_state;
        next_rst_cnt = rst_cnt;
        next_soft_reset = 1'b0;
        case (rst_state)
            fwp_pkg::RST_IDLE:
            begin
                if (frame_ok && opcode == fwp_pkg::OP_RESET_ENABLE)
                    next_rst_state = fwp_pkg::RST_ARMED; // RQ11
            end
            fwp_pkg::RST_ARMED:
            begin
                if (frame_ok && opcode == fwp_pkg::OP_RESET)
                begin
                    next_rst_state = fwp_pkg::RST_BUSY; // RQ11
                    next_rst_cnt = CNT_W'(RESET_CYCLES - 1); // RQ14
                    next_soft_reset = 1'b1; // RQ13
                end
                else if (frame_ok && opcode != fwp_pkg::OP_RESET_ENABLE)
                    next_rst_state = fwp_pkg::RST_IDLE; // RQ12
            end
            fwp_pkg::RST_BUSY:
            begin
                if (rst_cnt == '0)
                    next_rst_state = fwp_pkg::RST_IDLE;
                else
                    next_rst_cnt = rst_cnt - 1'b1; // RQ14
            end
            default:
                next_rst_state = fwp_pkg::RST_IDLE;
        endcase
    end
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            rst_state <= fwp_pkg::RST_IDLE;
            rst_cnt <= '0;
            soft_reset_pulse <= 1'b0;
        end
        else
        begin
            rst_state <= next_rst_state;
            rst_cnt <= next_rst_cnt;
            soft_reset_pulse <= next_soft_reset;
        end
    end
    assign reset_enabled = rst_state == fwp_pkg::RST_ARMED;
    assign reset_busy = rst_state == fwp_pkg::RST_BUSY;

    // ********************************
    // protection map
    // ********************************
    logic prot_hit;
    fwp_protect_map #(
        .ADDR_W(ADDR_W)
    ) fwp_protect_map_inst (
        .bits(protect_bits),
        .req_first(array_region.first),
        .req_last(array_region.last),
        .any(),
        .lo(),
        .hi(),
        .hit(prot_hit)
    );

    // ********************************
    // latch, protection bits and volatile state
    // ********************************
    logic next_wel;
    fwp_pkg::fwp_protect_s next_protect;
    fwp_pkg::fwp_volatile_s next_volatile;
    logic next_sr_done;
    logic next_sr_refused;
    logic next_grant;
    logic next_refused;
    always_comb
    begin
        next_wel = write_enable_latch;
        next_protect = protect_bits;
        next_volatile = volatile_state;
        next_sr_done = 1'b0;
        next_sr_refused = 1'b0;
        next_grant = 1'b0;
        next_refused = 1'b0;
        if (frame_ok && opcode == fwp_pkg::OP_WRITE_ENABLE)
            next_wel = 1'b1; // RQ16
        if (frame_ok && opcode == fwp_pkg::OP_WRITE_DISABLE)
            next_wel = 1'b0; // RQ1
        if (volatile_load && !reset_busy)
            next_volatile = volatile_value;
        // the pin only gates updates; the map decode never reads it
        if (sr_write_req)
        begin
            if (write_enable_latch && wp_s && !reset_busy) // RQ2 RQ9 RQ10
            begin
                next_protect = sr_write_bits; // RQ5
                next_sr_done = 1'b1;
            end
            else
                next_sr_refused = 1'b1;
        end
        if (array_req)
        begin
            if (write_enable_latch && !prot_hit && !reset_busy) // RQ2 RQ8
                next_grant = 1'b1;
            else
                next_refused = 1'b1;
        end
        // reset wins over latch and volatile-state updates in the same cycle; status writes and grants still go through
        if (next_soft_reset)
        begin
            next_wel = 1'b0; // RQ13
            next_volatile = fwp_pkg::VOLATILE_RESET; // RQ13
        end
    end
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            write_enable_latch <= 1'b0;
            protect_bits <= fwp_pkg::PROTECT_RESET;
            volatile_state <= fwp_pkg::VOLATILE_RESET;
            sr_write_done <= 1'b0;
            sr_write_refused <= 1'b0;
            array_grant <= 1'b0;
            array_refused <= 1'b0;
        end
        else
        begin
            write_enable_latch <= next_wel;
            protect_bits <= next_protect;
            volatile_state <= next_volatile;
            sr_write_done <= next_sr_done;
            sr_write_refused <= next_sr_refused;
            array_grant <= next_grant;
            array_refused <= next_refused;
        end
    end

    // ********************************
    // assertions
    // ********************************
    a_wrdi_clears: assert property (@(posedge clk_sys) disable iff (reset) // RQ1
        frame_ok && opcode == fwp_pkg::OP_WRITE_DISABLE |=> !write_enable_latch)
        else $error("write disable did not clear latch");
    a_wren_sets: assert property (@(posedge clk_sys) disable iff (reset) // RQ16
        frame_ok && opcode == fwp_pkg::OP_WRITE_ENABLE |=> write_enable_latch)
        else $error("write enable did not set latch");
    a_latch_gates: assert property (@(posedge clk_sys) disable iff (reset) // RQ2
        array_req && !write_enable_latch |=> array_refused && !array_grant)
        else $error("array request granted with latch clear");
    a_odd_abort: assert property (@(posedge clk_sys) disable iff (reset) // RQ4
        cs_rise && bit_cnt != 3'h0 && !soft_reset_pulse
        |=> write_enable_latch == $past(write_enable_latch))
        else $error("latch changed on aborted frame");
    a_protect_hit: assert property (@(posedge clk_sys) disable iff (reset) // RQ8
        array_req && prot_hit |=> !array_grant)
        else $error("protected region granted");
    a_wp_locks: assert property (@(posedge clk_sys) disable iff (reset) // RQ10
        !wp_s |=> protect_bits == $past(protect_bits))
        else $error("protection bits changed with pin low");
    a_reset_pair: assert property (@(posedge clk_sys) disable iff (reset) // RQ11
        $rose(reset_busy) |-> $past(rst_state) == fwp_pkg::RST_ARMED && soft_reset_pulse)
        else $error("reset without enable");
    a_disarm: assert property (@(posedge clk_sys) disable iff (reset) // RQ12
        reset_enabled && frame_ok && opcode != fwp_pkg::OP_RESET
        && opcode != fwp_pkg::OP_RESET_ENABLE |=> rst_state == fwp_pkg::RST_IDLE)
        else $error("armed state kept after other command");
    a_reset_clears: assert property (@(posedge clk_sys) disable iff (reset) // RQ13
        soft_reset_pulse |-> !write_enable_latch && volatile_state == fwp_pkg::VOLATILE_RESET)
        else $error("reset left volatile state");
    a_busy_length: assert property (@(posedge clk_sys) disable iff (reset) // RQ14
        $rose(reset_busy) |-> rst_cnt == CNT_W'(RESET_CYCLES - 1))
        else $error("reset time wrong");
    c_wrdi: cover property (@(posedge clk_sys) disable iff (reset)
        frame_ok && opcode == fwp_pkg::OP_WRITE_DISABLE && write_enable_latch);
    c_reset: cover property (@(posedge clk_sys) disable iff (reset) soft_reset_pulse);
    c_hit: cover property (@(posedge clk_sys) disable iff (reset) array_req && prot_hit);
    c_sr_ok: cover property (@(posedge clk_sys) disable iff (reset) sr_write_done);
endmodule

/* File: logic/fwp_pkg.sv */
// constants, types and behaviour list of the flash write-protect and soft-reset block
// Behaviour
// (RQ1) write-disable opcode, then chip select release, clears the write enable latch.
// (RQ2) with the latch clear, program, erase and status-write requests are refused.
// (RQ3) write-disable takes no address; bits after the opcode byte are discarded.
// (RQ4) release off a byte boundary aborts write-disable; the latch stays unchanged.
// (RQ5) complement plus five protect bits are non-volatile, changed by status write only.
// (RQ6) complement clear: size, end and fine bits select none, fractions or all.
// (RQ7) complement set protects exactly the part left open by the same code.
// (RQ8) erase or program touching any protected address is ignored.
// (RQ9) write-protect pin never changes which regions are protected.
// (RQ10) write-protect pin low rejects every change of the protection bits.
// (RQ11) software reset only on reset-enable immediately followed by reset.
// (RQ12) any other command after reset-enable leaves the armed state.
// (RQ13) accepted reset clears latch, suspend flags, read mode and wrap bits.
// (RQ14) reset takes about thirty microseconds; no commands accepted meanwhile.
// (RQ15) host should check busy and suspend flags clear before resetting.
// (RQ16) write-enable opcode, then release on a byte boundary, sets the latch.
// (RQ17) bits sampled msb first on rising serial clock while chip select low.
package fwp_pkg;
    // ********************************
    // opcodes and sizes
    // ********************************
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
    localparam logic [7:0] OP_RESET = 8'h99;
    localparam int ADDR_W = 19;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [3:0] SHIFT_COARSE_BASE = 4'h4;
    localparam logic [3:0] SHIFT_FINE_BASE = 4'h8;
    localparam logic [3:0] SHIFT_SIXTEENTH = 4'h4;
    // ********************************
    // timing
    // ********************************
    localparam int CLK_PERIOD_PS = 5000;
    localparam int RESET_TIME_US = 30;
    localparam int RESET_CYCLES = (RESET_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // ********************************
    // types
    // ********************************
    typedef struct packed {
        logic protect_complement;
        logic protect_fine_select;
        logic protect_bottom_select;
        logic protect_size_bit2;
        logic protect_size_bit1;
        logic protect_size_bit0;
    } fwp_protect_s;
    typedef struct packed {
        logic [ADDR_W-1:0] first;
        logic [ADDR_W-1:0] last;
    } fwp_region_s;
    typedef struct packed {
        logic [7:0] continuous_read_mode_bits;
        logic [2:0] wrap_length_bits;
        logic erase_suspended_flag;
        logic program_suspended_flag;
    } fwp_volatile_s;
    typedef enum logic [1:0] {
        RST_IDLE,
        RST_ARMED,
        RST_BUSY
    } fwp_reset_e;
    localparam fwp_protect_s PROTECT_RESET = 6'h00;
    localparam fwp_volatile_s VOLATILE_RESET = 13'h0000;
endpackage

/* File: logic/fwp_protect_map.sv */
// decoder from protection bits to the protected address segment, with overlap check
`timescale 1ns/10ps
module fwp_protect_map #(
    parameter int ADDR_W = fwp_pkg::ADDR_W
) (
    // protection setting
    input fwp_pkg::fwp_protect_s bits,
    // requested region
    input logic [ADDR_W-1:0] req_first,
    input logic [ADDR_W-1:0] req_last,
    // protected segment and overlap
    output logic any,
    output logic [ADDR_W-1:0] lo,
    output logic [ADDR_W-1:0] hi,
    output logic hit
);
    localparam logic [ADDR_W:0] MEM = {1'b1, {ADDR_W{1'b0}}};
    always_comb
    begin
        logic [3:0] shift;
        logic [3:0] code;
        logic none;
        logic all;
        logic bottom;
        logic [ADDR_W:0] len;
        logic [ADDR_W:0] seg;
        code = {2'b00, bits.protect_size_bit1, bits.protect_size_bit0};
        none = !bits.protect_size_bit2 && code == 4'h0;
        all = 1'b0;
        shift = 4'h0;
        if (!none)
        begin
            if (bits.protect_size_bit2)
            begin
                if (!bits.protect_fine_select || code == 4'h3)
                    all = 1'b1; // RQ6
                else
                    shift = fwp_pkg::SHIFT_SIXTEENTH; // RQ6
            end
            else if (bits.protect_fine_select)
                shift = fwp_pkg::SHIFT_FINE_BASE - code; // RQ6
            else
                shift = fwp_pkg::SHIFT_COARSE_BASE - code; // RQ6
        end
        len = none ? '0 : (all ? MEM : (MEM >> shift));
        // complement protects the other end, so the segment stays contiguous
        seg = bits.protect_complement ? MEM - len : len; // RQ7
        bottom = bits.protect_complement ^ bits.protect_bottom_select; // RQ7
        any = seg != '0;
        lo = bottom ? '0 : ADDR_W'(MEM - seg);
        hi = bottom ? ADDR_W'(seg - 1'b1) : ADDR_W'(MEM - 1'b1);
        hit = any && req_first <= hi && req_last >= lo; // RQ8
    end
endmodule

/* File: sim/fwp_spi_host.sv */
// spi host model that shifts flash opcodes into the block
`timescale 1ns/10ps
module fwp_spi_host (
    // clock
    input wire logic clk_sys,
    // serial pins
    output logic spi_sck,
    output logic spi_cs_n,
    output logic spi_mosi
);
    initial
    begin
        spi_sck = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end
    // ********************************
    // frame driver
    // ********************************
    // sck stands low outside frames; a count off a byte boundary breaks the frame on purpose
    task automatic send(input logic [15:0] word, input int nbits);
        int i;
        @(negedge clk_sys);
        spi_cs_n = 1'b0;
        for (i = 0; i < nbits; i++)
        begin
            spi_mosi = word[15-i];
            repeat (4) @(negedge clk_sys);
            spi_sck = 1'b1;
            repeat (4) @(negedge clk_sys);
            spi_sck = 1'b0;
        end
        repeat (4) @(negedge clk_sys);
        spi_cs_n = 1'b1;
        // released data line shows the inverse so a stale bit is never trusted
        spi_mosi = ~spi_mosi;
        repeat (8) @(negedge clk_sys);
    endtask
    // reset-enable then reset with nothing in between
    task automatic reset_pair();
        send({fwp_pkg::OP_RESET_ENABLE, 8'h00}, 8);
        send({fwp_pkg::OP_RESET, 8'h00}, 8);
    endtask
endmodule

/* File: sim/testbench.sv */
// self-checking bench for the write-protect and soft-reset core
`timescale 1ns/10ps
module testbench;
    localparam int RST_CYC = 200;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic spi_sck;
    logic spi_cs_n;
    logic spi_mosi;
    logic wp_n = 1'b1;
    logic sr_write_req = 1'b0;
    fwp_pkg::fwp_protect_s sr_write_bits = 6'h00;
    logic sr_write_done;
    logic sr_write_refused;
    logic array_req = 1'b0;
    fwp_pkg::fwp_region_s array_region = 38'h00_0000_0000;
    logic array_grant;
    logic array_refused;
    logic volatile_load = 1'b0;
    fwp_pkg::fwp_volatile_s volatile_value = 13'h0000;
    logic write_enable_latch;
    fwp_pkg::fwp_protect_s protect_bits;
    fwp_pkg::fwp_volatile_s volatile_state;
    logic reset_enabled;
    logic reset_busy;
    logic soft_reset_pulse;
    int mismatches = 0;
    int n_checks = 0;
    int n_soft = 0;
    int cyc = 0;
    int t_soft = 0;
    always #2.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
    begin
        cyc++;
        if (soft_reset_pulse === 1'b1)
        begin
            n_soft++;
            t_soft = cyc;
        end
    end
    fwp_spi_host fwp_spi_host_inst (.clk_sys(clk_sys), .spi_sck(spi_sck),
        .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi));
    fwp_core #(.RESET_CYCLES(RST_CYC)) fwp_core_inst (.clk_sys(clk_sys), .reset(reset),
        .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .wp_n(wp_n),
        .sr_write_req(sr_write_req), .sr_write_bits(sr_write_bits),
        .sr_write_done(sr_write_done), .sr_write_refused(sr_write_refused),
        .array_req(array_req), .array_region(array_region), .array_grant(array_grant),
        .array_refused(array_refused), .volatile_load(volatile_load),
        .volatile_value(volatile_value), .write_enable_latch(write_enable_latch),
        .protect_bits(protect_bits), .volatile_state(volatile_state),
        .reset_enabled(reset_enabled), .reset_busy(reset_busy),
        .soft_reset_pulse(soft_reset_pulse));
    // ********************************
    // shared tasks
    // ********************************
    task automatic check(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'b1)
        begin
            mismatches++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic op(input logic [7:0] code);
        fwp_spi_host_inst.send({code, 8'h00}, 8);
    endtask
    // answers are caught over two cycles so a one-cycle pulse is never missed
    task automatic sr_write(input logic [5:0] b, output logic d, output logic r);
        @(negedge clk_sys);
        sr_write_bits = b;
        sr_write_req = 1'b1;
        @(negedge clk_sys);
        sr_write_req = 1'b0;
        d = sr_write_done;
        r = sr_write_refused;
        @(negedge clk_sys);
        d = d | sr_write_done;
        r = r | sr_write_refused;
    endtask
    task automatic arr(input logic [18:0] f, input logic [18:0] l, output logic g,
        output logic r);
        @(negedge clk_sys);
        array_region = {f, l};
        array_req = 1'b1;
        @(negedge clk_sys);
        array_req = 1'b0;
        g = array_grant;
        r = array_refused;
        @(negedge clk_sys);
        g = g | array_grant;
        r = r | array_refused;
    endtask
    task automatic probe(input logic [5:0] b, input logic [18:0] f, input logic [18:0] l,
        input logic exp_ref);
        logic d;
        logic r;
        logic g;
        sr_write(b, d, r);
        check(d === 1'b1 && r === 1'b0 && protect_bits === b, "status write lost");
        arr(f, l, g, r);
        check(r === exp_ref && g === ~exp_ref, "protected range wrong");
    endtask
    // ********************************
    // scenarios
    // ********************************
    task automatic t_latch();
        op(fwp_pkg::OP_WRITE_ENABLE);
        check(write_enable_latch === 1'b1, "write enable ignored");
        fwp_spi_host_inst.send({fwp_pkg::OP_WRITE_DISABLE, 8'h5A}, 16);
        check(write_enable_latch === 1'b0, "disable with data failed");
        op(fwp_pkg::OP_WRITE_ENABLE);
        fwp_spi_host_inst.send({fwp_pkg::OP_WRITE_DISABLE, 8'h00}, 12);
        check(write_enable_latch === 1'b1, "12-bit disable acted");
        fwp_spi_host_inst.send({fwp_pkg::OP_WRITE_DISABLE, 8'h00}, 5);
        check(write_enable_latch === 1'b1, "short disable acted");
        op(fwp_pkg::OP_WRITE_DISABLE);
        check(write_enable_latch === 1'b0, "disable failed");
    endtask
    task automatic t_refuse();
        logic d;
        logic r;
        logic g;
        sr_write(6'h01, d, r);
        check(r === 1'b1 && d === 1'b0 && protect_bits === 6'h00, "status write taken");
        arr(19'h0_0000, 19'h0_0000, g, r);
        check(r === 1'b1 && g === 1'b0, "array write taken");
    endtask
    task automatic t_map();
        op(fwp_pkg::OP_WRITE_ENABLE);
        probe(6'h00, 19'h0_0000, 19'h0_0000, 1'b0);
        probe(6'h18, 19'h7_FFFF, 19'h7_FFFF, 1'b0);
        probe(6'h01, 19'h7_0000, 19'h7_0000, 1'b1);
        probe(6'h01, 19'h6_FFFF, 19'h6_FFFF, 1'b0);
        probe(6'h01, 19'h6_FFF0, 19'h7_0010, 1'b1);
        probe(6'h0B, 19'h3_FFFF, 19'h3_FFFF, 1'b1);
        probe(6'h0B, 19'h4_0000, 19'h7_FFFF, 1'b0);
        probe(6'h04, 19'h5_0000, 19'h5_0000, 1'b1);
        probe(6'h11, 19'h7_F000, 19'h7_F000, 1'b1);
        probe(6'h11, 19'h7_EFFF, 19'h7_EFFF, 1'b0);
        probe(6'h1E, 19'h0_7FFF, 19'h0_7FFF, 1'b1);
        probe(6'h1E, 19'h0_8000, 19'h0_8000, 1'b0);
        probe(6'h1F, 19'h4_0000, 19'h4_0000, 1'b1);
        probe(6'h20, 19'h7_FFFF, 19'h7_FFFF, 1'b1);
        probe(6'h21, 19'h6_FFFF, 19'h6_FFFF, 1'b1);
        probe(6'h21, 19'h7_0000, 19'h7_FFFF, 1'b0);
        probe(6'h24, 19'h0_0000, 19'h7_FFFF, 1'b0);
        probe(6'h3B, 19'h0_4000, 19'h0_4000, 1'b1);
        probe(6'h3B, 19'h0_3FFF, 19'h0_3FFF, 1'b0);
        probe(6'h01, 19'h7_0000, 19'h7_0000, 1'b1);
    endtask
    task automatic t_wp();
        logic d;
        logic r;
        logic g;
        @(negedge clk_sys);
        wp_n = 1'b0;
        repeat (4) @(negedge clk_sys);
        sr_write(6'h00, d, r);
        check(r === 1'b1 && d === 1'b0 && protect_bits === 6'h01, "locked bits moved");
        arr(19'h7_0000, 19'h7_0000, g, r);
        check(r === 1'b1 && g === 1'b0, "lock changed the map");
        arr(19'h6_FFFF, 19'h6_FFFF, g, r);
        check(g === 1'b1 && r === 1'b0, "lock changed the map");
        wp_n = 1'b1;
    endtask
    task automatic t_reset();
        int i;
        @(negedge clk_sys);
        volatile_value = 13'h1FFF;
        volatile_load = 1'b1;
        @(negedge clk_sys);
        volatile_load = 1'b0;
        check(volatile_state === 13'h1FFF, "volatile load lost");
        op(fwp_pkg::OP_RESET_ENABLE);
        check(reset_enabled === 1'b1, "reset enable ignored");
        op(fwp_pkg::OP_WRITE_ENABLE);
        check(reset_enabled === 1'b0, "other opcode kept arming");
        op(fwp_pkg::OP_RESET);
        check(n_soft == 0 && reset_busy === 1'b0, "unarmed reset acted");
        check(reset_busy === 1'b0 && volatile_state === 13'h1FFF, "busy before reset");
        fwp_spi_host_inst.reset_pair();
        check(n_soft == 1 && reset_busy === 1'b1, "reset pair ignored");
        check(write_enable_latch === 1'b0 && volatile_state === 13'h0000, "state kept");
        check(reset_enabled === 1'b0 && protect_bits === 6'h01, "bits lost");
        op(fwp_pkg::OP_WRITE_ENABLE);
        check(write_enable_latch === 1'b0, "command taken while busy");
        for (i = 0; i < RST_CYC && reset_busy === 1'b1; i++)
            @(negedge clk_sys);
        check(reset_busy === 1'b0, "reset never ends");
        i = cyc - t_soft;
        check(i >= RST_CYC - 2 && i <= RST_CYC + 2, "reset length wrong");
        op(fwp_pkg::OP_WRITE_ENABLE);
        check(write_enable_latch === 1'b1, "no command after reset");
    endtask
    // ********************************
    // main sequence and watchdog
    // ********************************
    initial
    begin
        repeat (12) @(negedge clk_sys);
        reset = 1'b0;
        check(write_enable_latch === 1'b0 && protect_bits === 6'h00, "reset values");
        repeat (4) @(negedge clk_sys);
        t_latch();
        t_refuse();
        t_map();
        t_wp();
        t_reset();
        stop_test();
    end
    // the whole run needs under 20 us; five times that means a hang
    initial
    begin
        #100000;
        mismatches++;
        $display("[ERR] %0t watchdog expired", $time);
        stop_test();
    end
endmodule
